// [include/mscnt_pkg.sv]
package mscnt_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_STATS_CONTROL      = 12'h100;
    localparam logic [11:0] OFS_RESERVED_CONTROL_A = 12'h10c;
    localparam logic [11:0] OFS_RESERVED_CONTROL_B = 12'h110;
    localparam logic [11:0] OFS_RX_FRAMES_TOTAL    = 12'h200;
    localparam logic [11:0] OFS_RX_FRAMES_GOOD     = 12'h204;
    localparam logic [11:0] OFS_TX_FRAMES_TOTAL    = 12'h300;
    localparam logic [11:0] OFS_TX_BYTES_TOTAL     = 12'h308;
    localparam logic [11:0] OFS_TX_BYTES_GOOD      = 12'h30c;
    localparam logic [11:0] OFS_LONG_FRAMES        = 12'h318;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          MAX_FRAME_LSB     = 3;
    localparam int          MAX_FRAME_MSB     = 13;
    localparam int          MAX_FRAME_W       = 11;
    localparam int          FRAME_LEN_W       = 16;
    localparam logic [31:0] CTRL_WRITE_MASK   = 32'h0000_3ffa;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_2f72;
    localparam logic [31:0] RSVD_RESET        = 32'h0000_0000;
    localparam logic [31:0] CNT_RESET         = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
    localparam logic [11:0] ADDR_MASK         = 12'hffc;

    // ------------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ        = 2'h3;

endpackage

// [rtl/mscnt_top.sv]
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps

module mscnt_top (
    input  wire logic        clk_sys_in,        // System clock, 25 MHz.
    input  wire logic        sys_rst_in,        // Synchronous reset, active high.
    input  wire logic        hsel_in,           // AHB slave select.
    input  wire logic [31:0] haddr_in,          // AHB address.
    input  wire logic [1:0]  htrans_in,         // AHB transfer type.
    input  wire logic        hwrite_in,         // AHB write strobe.
    input  wire logic [2:0]  hsize_in,          // AHB transfer size.
    input  wire logic [31:0] hwdata_in,         // AHB write data.
    input  wire logic        hready_in,         // AHB bus ready.
    output logic      [31:0] hrdata_out,        // AHB read data.
    output logic             hreadyout_out,     // AHB slave ready.
    output logic             hresp_out,         // AHB response, always OKAY.
    input  wire logic        rx_frame_done_in,  // Pulse: a frame was received.
    input  wire logic        rx_frame_ok_in,    // With done: frame was valid.
    input  wire logic        tx_frame_done_in,  // Pulse: a frame was transmitted.
    input  wire logic [15:0] tx_frame_len_in,   // With done: frame size in bytes.
    input  wire logic        tx_byte_in,        // Pulse: a byte was transmitted.
    input  wire logic        tx_byte_ok_in,     // With byte: byte was valid.
    output logic             tx_long_frame_out, // Pulse: last frame was long.
    output logic [10:0]      max_frame_len_out, // Current max frame length.
    output logic             ctrl_bit1_out      // Control bit 1 as written.
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] cnt_step(input logic [31:0] v, input logic inc);
        // Plain modular add: no saturation, so all ones goes to zero.
        cnt_step = inc ? v + 32'h0000_0001 : v;
    endfunction

    // Only the length field and bit 1 take writes; every other control bit
    // stays at its reset level so that stray software writes cannot set it.
    function automatic logic [31:0] merge_ctrl(input logic [31:0] old_v,
                                               input logic [31:0] new_v);
        merge_ctrl = (new_v & mscnt_pkg::CTRL_WRITE_MASK) |
                     (old_v & ~mscnt_pkg::CTRL_WRITE_MASK);
    endfunction

    // ------------------------------------------------------------------
    // Bus slave: address phase capture
    // ------------------------------------------------------------------
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic        addr_ok;
    logic        rd_req;
    logic [11:0] req_addr;

    assign addr_ok  = hsel_in && hready_in &&
                      (htrans_in == mscnt_pkg::HTRANS_NONSEQ ||
                       htrans_in == mscnt_pkg::HTRANS_SEQ);
    assign rd_req   = addr_ok && !hwrite_in;
    assign req_addr = haddr_in[11:0] & mscnt_pkg::ADDR_MASK;

    // Zero wait states: writes land on the edge that ends the data phase.
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite_in;
            wr_addr_q <= req_addr;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] rsvd_a_q;
    logic [31:0] rsvd_b_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q <= mscnt_pkg::CTRL_RESET;
        end
        else if (wr_pend_q && wr_addr_q == mscnt_pkg::OFS_STATS_CONTROL)
        begin
            ctrl_q <= merge_ctrl(ctrl_q, hwdata_in);
        end
    end

    // The reserved words are plain storage; software is expected to fill
    // them with ones, and they read back what was written.
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            rsvd_a_q <= mscnt_pkg::RSVD_RESET;
            rsvd_b_q <= mscnt_pkg::RSVD_RESET;
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == mscnt_pkg::OFS_RESERVED_CONTROL_A)
            begin
                rsvd_a_q <= hwdata_in;
            end
            if (wr_addr_q == mscnt_pkg::OFS_RESERVED_CONTROL_B)
            begin
                rsvd_b_q <= hwdata_in;
            end
        end
    end

    assign max_frame_len_out = ctrl_q[mscnt_pkg::MAX_FRAME_MSB:mscnt_pkg::MAX_FRAME_LSB];
    assign ctrl_bit1_out     = ctrl_q[1];

    // ------------------------------------------------------------------
    // Statistics counters
    // ------------------------------------------------------------------
    logic [31:0] rx_frame_total_count_q;
    logic [31:0] rx_frame_valid_count_q;
    logic [31:0] tx_frame_total_count_q;
    logic [31:0] tx_byte_total_count_q;
    logic [31:0] tx_byte_valid_count_q;
    logic [31:0] tx_long_count_q;
    logic        is_long;

    assign is_long = tx_frame_len_in > {5'h00, max_frame_len_out};

    // Each counter has its own process. None of them has a bus write path,
    // so software can only observe them; this keeps a host that measures
    // intervals from ever losing an event to a badly timed write.
    // cleared by reset only

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            rx_frame_total_count_q <= mscnt_pkg::CNT_RESET;
        end
        else
        begin
            rx_frame_total_count_q <= cnt_step(rx_frame_total_count_q, rx_frame_done_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            rx_frame_valid_count_q <= mscnt_pkg::CNT_RESET;
        end
        else
        begin
            rx_frame_valid_count_q <= cnt_step(rx_frame_valid_count_q,
                                               rx_frame_done_in && rx_frame_ok_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            tx_frame_total_count_q <= mscnt_pkg::CNT_RESET;
        end
        else
        begin
            tx_frame_total_count_q <= cnt_step(tx_frame_total_count_q, tx_frame_done_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            tx_long_count_q <= mscnt_pkg::CNT_RESET;
        end
        else
        begin
            tx_long_count_q <= cnt_step(tx_long_count_q, tx_frame_done_in && is_long);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            tx_long_frame_out <= 1'b0;
        end
        else
        begin
            tx_long_frame_out <= tx_frame_done_in && is_long;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            tx_byte_total_count_q <= mscnt_pkg::CNT_RESET;
        end
        else
        begin
            tx_byte_total_count_q <= cnt_step(tx_byte_total_count_q, tx_byte_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            tx_byte_valid_count_q <= mscnt_pkg::CNT_RESET;
        end
        else
        begin
            tx_byte_valid_count_q <= cnt_step(tx_byte_valid_count_q,
                                              tx_byte_in && tx_byte_ok_in);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // A 32-bit word on the bus carries bit 31 in the top lane, as stored.
    // Unmapped words read as zero rather than aliasing a neighbour, so a
    // wrong software offset shows up as a stuck zero, not as plausible data.
    logic [31:0] rd_mux;

    always_comb
    begin
        case (req_addr)
            mscnt_pkg::OFS_STATS_CONTROL:      rd_mux = ctrl_q;
            mscnt_pkg::OFS_RESERVED_CONTROL_A: rd_mux = rsvd_a_q;
            mscnt_pkg::OFS_RESERVED_CONTROL_B: rd_mux = rsvd_b_q;
            mscnt_pkg::OFS_RX_FRAMES_TOTAL:    rd_mux = rx_frame_total_count_q;
            mscnt_pkg::OFS_RX_FRAMES_GOOD:     rd_mux = rx_frame_valid_count_q;
            mscnt_pkg::OFS_TX_FRAMES_TOTAL:    rd_mux = tx_frame_total_count_q;
            mscnt_pkg::OFS_TX_BYTES_TOTAL:     rd_mux = tx_byte_total_count_q;
            mscnt_pkg::OFS_TX_BYTES_GOOD:      rd_mux = tx_byte_valid_count_q;
            mscnt_pkg::OFS_LONG_FRAMES:        rd_mux = tx_long_count_q;
            default:                           rd_mux = mscnt_pkg::READ_ZERO;
        endcase
    end

    // Read data is registered at the address phase so that it stands for
    // the whole data phase; a read never disturbs any counter.
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            hrdata_out <= mscnt_pkg::READ_ZERO;
        end
        else if (rd_req)
        begin
            hrdata_out <= rd_mux;
        end
    end

endmodule

// [verification/mscnt_props.sv]
`timescale 1ns/100ps
module mscnt_props (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        tx_frame_done_in,
    input wire logic [15:0] tx_frame_len_in,
    input wire logic        tx_long_frame_out,
    input wire logic [10:0] max_frame_len_out,
    input wire logic        ctrl_bit1_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // A control access is taken in its address phase; a write lands one edge later.
    wire logic ctl_acc = hsel_in && hready_in && htrans_in[1]
                         && (haddr_in[11:2] == mscnt_pkg::OFS_STATS_CONTROL[11:2]);
    wire logic long_in = tx_frame_done_in && (tx_frame_len_in > {5'h0, max_frame_len_out});
    sequence s_ctl_wr;
        ctl_acc && hwrite_in ##1 1'b1;
    endsequence
    sequence s_ctl_rd;
        ctl_acc && !hwrite_in;
    endsequence
    chk_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("slave not ready or not okay");
    chk_long_set: assert property (long_in |=> tx_long_frame_out)
        else $error("long frame not flagged");
    chk_long_clear: assert property (!long_in |=> !tx_long_frame_out)
        else $error("long flag without long frame");
    chk_max_write: assert property
        (s_ctl_wr |=> max_frame_len_out == $past(hwdata_in[13:3]))
        else $error("max frame length not written");
    chk_bit1_write: assert property (s_ctl_wr |=> ctrl_bit1_out == $past(hwdata_in[1]))
        else $error("control bit 1 not written");
    chk_ctrl_hold: assert property
        (!$past(ctl_acc && hwrite_in, 2) |->
         $stable(max_frame_len_out) && $stable(ctrl_bit1_out))
        else $error("control changed without a write");
    chk_ctrl_read: assert property
        (s_ctl_rd |=> hrdata_out[13:3] == $past(max_frame_len_out) &&
         hrdata_out[1] == $past(ctrl_bit1_out))
        else $error("control read data wrong");
    chk_ctrl_zeros: assert property (s_ctl_rd |=> (hrdata_out & ~mscnt_pkg::CTRL_WRITE_MASK) == 32'h0)
        else $error("reserved control bits not zero");
    chk_reset_value: assert property ($fell(sys_rst_in) |-> max_frame_len_out == 11'h5ee && ctrl_bit1_out)
        else $error("control reset value wrong");
endmodule
bind mscnt_top mscnt_props u_props (.*);

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    logic        clk_sys_in = 1'b0, sys_rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
    logic        rx_frame_done_in = 1'b0, rx_frame_ok_in = 1'b0, tx_frame_done_in = 1'b0;
    logic        tx_byte_in = 1'b0, tx_byte_ok_in = 1'b0, exp_long;
    logic        hreadyout_out, hresp_out, tx_long_frame_out, ctrl_bit1_out;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd, exp_lcnt, exp_cnt [5];
    logic [1:0]  htrans_in = 2'h0;
    logic [2:0]  hsize_in = 3'h2;
    logic [15:0] tx_frame_len_in = 16'h0, seed = 16'h24fd;
    logic [10:0] max_frame_len_out, max_v;
    logic [11:0] cnt_ofs [5] = '{mscnt_pkg::OFS_RX_FRAMES_TOTAL, mscnt_pkg::OFS_RX_FRAMES_GOOD,
        mscnt_pkg::OFS_TX_FRAMES_TOTAL, mscnt_pkg::OFS_TX_BYTES_TOTAL, mscnt_pkg::OFS_TX_BYTES_GOOD};
    wire logic   hready_in = hreadyout_out;
    int          err_count = 0, check_count = 0, i, k;
    mscnt_top dut (.*);
    initial forever #20 clk_sys_in = ~clk_sys_in;
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function logic is_long(input logic [15:0] len, input logic [10:0] max);
        return len > {5'h0, max};
    endfunction
    task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // The slave has no wait states, but a stuck ready must not hang the run.
    task wait_ready;
        int n;
        n = 0;
        @(posedge clk_sys_in);
        while (hready_in !== 1'b1)
        begin
            n++;
            if (n > 64)
            begin
                err_count++;
                finish_test;
            end
            @(posedge clk_sys_in);
        end
    endtask
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel_in <= 1'b1;
        haddr_in <= {20'h0, a};
        htrans_in <= mscnt_pkg::HTRANS_NONSEQ;
        hwrite_in <= wr;
        wait_ready;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        wait_ready;
        r = hrdata_out;
    endtask
    task traffic(input int n);
        for (int j = 0; j <= n; j++)
        begin
            @(posedge clk_sys_in);
            // Model what the design sampled at this edge before new values land.
            exp_cnt[0] += 32'(rx_frame_done_in);
            exp_cnt[1] += 32'(rx_frame_done_in && rx_frame_ok_in);
            exp_cnt[2] += 32'(tx_frame_done_in);
            exp_cnt[3] += 32'(tx_byte_in);
            exp_cnt[4] += 32'(tx_byte_in && tx_byte_ok_in);
            exp_long = tx_frame_done_in && is_long(tx_frame_len_in, max_v);
            exp_lcnt += 32'(exp_long);
            seed = lfsr_next(seed);
            rx_frame_done_in <= seed[0] && j < n;
            rx_frame_ok_in <= seed[1];
            tx_frame_done_in <= (seed[2] || j < 3) && j < n;
            tx_frame_len_in <= (j < 3) ? 16'({5'h0, max_v} + j - 1) : 16'({5'h0, max_v} + seed[7:4] - 8);
            tx_byte_in <= seed[8] && j < n;
            tx_byte_ok_in <= seed[9];
            @(negedge clk_sys_in);
            check("long frame", exp_long, tx_long_frame_out);
        end
        // Bus requests start only right after a rising edge.
        @(posedge clk_sys_in);
    endtask
    // ------------------------------------------------------------------
    // Main sequence: the second pass proves that reset alone clears counts.
    // ------------------------------------------------------------------
    initial
    begin
        for (k = 0; k < 2; k++)
        begin
            sys_rst_in <= 1'b1;
            repeat (5) @(posedge clk_sys_in);
            sys_rst_in <= 1'b0;
            @(posedge clk_sys_in);
            exp_cnt = '{default: 32'h0};
            exp_lcnt = 32'h0;
            xfer(1'b0, mscnt_pkg::OFS_STATS_CONTROL, 32'h0, rd);
            check("ctrl reset", mscnt_pkg::CTRL_RESET, rd);
            for (i = 0; i < 5; i++)
            begin
                xfer(1'b0, cnt_ofs[i], 32'h0, rd);
                check("counter reset", 32'h0, rd);
            end
            seed = lfsr_next(seed);
            max_v = seed[10:0] | 11'h100;
            xfer(1'b1, mscnt_pkg::OFS_STATS_CONTROL, {18'h0, max_v, 3'h2}, rd);
            xfer(1'b1, mscnt_pkg::OFS_RESERVED_CONTROL_A, 32'hffffffff, rd);
            xfer(1'b1, mscnt_pkg::OFS_RESERVED_CONTROL_B, 32'hffffffff, rd);
            xfer(1'b0, mscnt_pkg::OFS_STATS_CONTROL, 32'h0, rd);
            check("ctrl", {18'h0, max_v, 3'h2}, rd);
            xfer(1'b0, mscnt_pkg::OFS_RESERVED_CONTROL_A, 32'h0, rd);
            check("reserved a", 32'hffffffff, rd);
            xfer(1'b0, mscnt_pkg::OFS_RESERVED_CONTROL_B, 32'h0, rd);
            check("reserved b", 32'hffffffff, rd);
            traffic(300);
            xfer(1'b0, mscnt_pkg::OFS_LONG_FRAMES, 32'h0, rd);
            check("long count", exp_lcnt, rd);
            for (i = 0; i < 10; i++)
            begin
                if (i >= 5)
                    xfer(1'b1, cnt_ofs[i - 5], {seed, seed}, rd);
                xfer(1'b0, cnt_ofs[i % 5], 32'h0, rd);
                check("counter", exp_cnt[i % 5], rd);
            end
            xfer(1'b1, 12'h400, 32'hffffffff, rd);
            xfer(1'b0, 12'h400, 32'h0, rd);
            check("unmapped", 32'h0, rd);
        end
        finish_test;
    end
endmodule
